// ==== hdl/iwd_pkg.sv ====
// constants, types and state layout for the instruction word decoder
// assumes a 14-bit program word and one core clock per oscillator period
package iwd_pkg;

  localparam int          IWD_WORD_W      = 14;
  localparam int          IWD_FADDR_W     = 7;
  localparam int          IWD_BIT_W       = 3;
  localparam int          IWD_DATA_W      = 8;
  localparam int          IWD_LIT11_W     = 11;
  localparam int          IWD_OSC_PER_CYC = 4;
  localparam int          IWD_CLK_NS      = 50;
  localparam int          IWD_ICYC_NS     = IWD_OSC_PER_CYC * IWD_CLK_NS;
  localparam int          IWD_ICYC_CLKS   = IWD_ICYC_NS / IWD_CLK_NS;
  localparam logic [1:0]  IWD_PH_LAST     = 2'(IWD_ICYC_CLKS - 1);
  localparam logic [1:0]  IWD_PH_READ     = 2'h0;
  localparam logic [1:0]  IWD_PH_WRITE    = 2'h2;
  localparam logic [6:0]  IWD_FADDR_MAX   = 7'h7F;
  localparam logic [5:0]  IWD_INDIRECT_HI = 6'h00;
  // major group in word bits 13:12
  localparam logic [1:0]  IWD_GRP_BYTE    = 2'h0;
  localparam logic [1:0]  IWD_GRP_BIT     = 2'h1;
  localparam logic [1:0]  IWD_GRP_JMP     = 2'h2;
  localparam logic [1:0]  IWD_GRP_LIT     = 2'h3;
  localparam logic [3:0]  IWD_OP_DEC_SKIP = 4'hB;
  localparam logic [3:0]  IWD_OP_INC_SKIP = 4'hF;
  localparam logic [1:0]  IWD_BOP_TEST_CLR = 2'h2;
  localparam logic [1:0]  IWD_BOP_TEST_SET = 2'h3;
  localparam logic [13:0] IWD_W_SUB_EXIT  = 14'h0008;
  localparam logic [13:0] IWD_W_INT_EXIT  = 14'h0009;
  localparam logic [13:0] IWD_W_COMP_CALL = 14'h000A;
  localparam logic [13:0] IWD_W_ACC_JUMP  = 14'h000B;
  localparam logic [9:0]  IWD_W_PTR_UPD   = 10'h001;
  localparam logic [3:0]  IWD_W_LIT_EXIT  = 4'hD;
  localparam logic [4:0]  IWD_W_REL_JUMP  = 5'h19;
  localparam logic [5:0]  IWD_W_PTR_OFS   = 6'h3F;
  localparam logic [3:0]  IWD_SHIFT_OPS   = 4'h5;

  typedef enum logic [1:0] {
    IWD_CLS_BYTE = 2'h0,
    IWD_CLS_BIT  = 2'h1,
    IWD_CLS_LIT  = 2'h2
  } iwd_class_t;

  typedef enum logic [1:0] {
    IWD_PM_PRE_INC  = 2'h0,
    IWD_PM_PRE_DEC  = 2'h1,
    IWD_PM_POST_INC = 2'h2,
    IWD_PM_POST_DEC = 2'h3
  } iwd_ptr_mode_t;

  typedef enum logic [1:0] {
    IWD_SK_NONE = 2'h0,
    IWD_SK_CLR  = 2'h1,
    IWD_SK_SET  = 2'h2,
    IWD_SK_ZERO = 2'h3
  } iwd_skip_t;

  // gray along execute -> second -> third
  typedef enum logic [1:0] {
    IWD_ST_EXEC   = 2'h0,
    IWD_ST_SECOND = 2'h1,
    IWD_ST_THIRD  = 2'h3
  } iwd_state_t;

  typedef struct packed {
    iwd_class_t         cls;
    logic [6:0]         f_addr;
    logic [2:0]         bit_idx;
    logic               dest_file;
    logic               ptr_num;
    iwd_ptr_mode_t      ptr_mode;
    logic [7:0]         lit8;
    logic [10:0]        lit11;
    logic               names_file;
    logic               file_store;
    logic               two_cyc;
    iwd_skip_t          skip;
    logic               indirect;
    logic               ptr_upd;
  } iwd_dec_t;

  typedef struct packed {
    iwd_state_t         st;
    logic [1:0]         ph;
    iwd_dec_t           dec;
    logic [7:0]         mask;
    logic               need_two;
    logic               need_ind;
    logic [1:0]         ncnt;
    logic [1:0]         ncyc;
    logic               rd_done;
    logic               skip_taken;
    logic               fetch;
    logic               file_rd;
    logic               file_wr;
    logic               acc_wr;
    logic               flush;
    logic               ptr_inc;
    logic               ptr_dec;
    logic               busy;
  } iwd_s_t;

  localparam iwd_s_t IWD_S_RESET = '{st: IWD_ST_EXEC, ph: IWD_PH_LAST, default: '0};

endpackage

// ==== hdl/iwd_decode_timing.sv ====
// instruction word decoder with four-phase instruction cycle sequencer
// assumes program memory presents the next word while fetch_out is high,
// and the datapath returns the tested bit and the zero result in phase 3
// Notes on behaviour
// [RL1] one 14-bit word holds opcode and operands
// [RL2] sort into byte, bit, literal/control classes
// [RL3] default: one instruction cycle per instruction
// [RL4] both subroutine calls take two cycles
// [RL5] all three returns take two cycles
// [RL6] jumps and taken skips take two cycles
// [RL7] indirect access into program memory adds cycle
// [RL8] instruction cycle is four oscillator periods
// [RL9] named file register is read, modified, stored
// [RL10] read happens even for write-only instructions
// [RL11] file address spans 0x00 to 0x7F
// [RL12] bit index selects one of eight bits
// [RL13] destination bit: 0 accumulator, 1 file
// [RL14] don't-care bits ignored at either level
// [RL15] pointer number picks one of two pointers
// [RL16] two-bit mode: pre/post increment/decrement
// [RL17] byte ops: opcode, destination, low 7-bit address
// [RL18] bit ops: 3-bit index above address
// [RL19] literal ops: 8-bit immediate in low byte
// [RL20] absolute call/jump: 11-bit low-order target
// [RL21] untaken skip finishes in one cycle
`timescale 1ns/1ps
module iwd_decode_timing (
  input  wire logic                 core_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 clk_en_in,
  input  wire logic [13:0]          instr_in,
  input  wire logic                 test_bit_in,
  input  wire logic                 result_zero_in,
  input  wire logic [1:0]           ptr_in_prog_in,
  output logic                      fetch_out,
  output logic [1:0]                phase_out,
  output iwd_pkg::iwd_dec_t         dec_out,
  output logic [7:0]                bit_mask_out,
  output logic                      file_rd_out,
  output logic                      file_wr_out,
  output logic                      acc_wr_out,
  output logic                      flush_out,
  output logic                      ptr_inc_out,
  output logic                      ptr_dec_out,
  output logic                      busy_out,
  output logic [1:0]                cycles_out
);

  function automatic iwd_pkg::iwd_dec_t decode(input logic [13:0] w);
    iwd_pkg::iwd_dec_t d;
    logic              ctl_low;
    d       = '0;
    ctl_low = (w[13:7] == 7'h00);
    d.f_addr  = w[6:0];                                        // see [RL17] [RL11]
    d.bit_idx = w[9:7];                                        // see [RL18]
    d.lit8    = w[7:0];                                        // see [RL19]
    d.lit11   = w[10:0];                                       // see [RL20]
    d.dest_file = w[7];                                        // see [RL13]
    d.ptr_mode  = iwd_pkg::iwd_ptr_mode_t'(w[1:0]);           // see [RL16]
    d.cls = iwd_pkg::IWD_CLS_LIT;                              // see [RL2]
    unique case (w[13:12])
      iwd_pkg::IWD_GRP_BYTE: begin
        if (!ctl_low) begin
          d.cls = iwd_pkg::IWD_CLS_BYTE;
        end
      end
      iwd_pkg::IWD_GRP_BIT: begin
        d.cls       = iwd_pkg::IWD_CLS_BIT;
        d.dest_file = 1'b1;
      end
      iwd_pkg::IWD_GRP_LIT: begin
        if (w[11:8] >= iwd_pkg::IWD_SHIFT_OPS && w[11:8] != 4'h8 && w[11:8] != 4'hF &&
            (w[11:8] == 4'h5 || w[11:8] == 4'h6 || w[11:8] == 4'h7 ||
             w[11:8] == 4'hB || w[11:8] == 4'hD)) begin
          d.cls = iwd_pkg::IWD_CLS_BYTE;
        end
      end
      default: begin
        d.cls = iwd_pkg::IWD_CLS_LIT;
      end
    endcase
    // clear-accumulator form leaves address bits as don't-care
    d.names_file = (d.cls != iwd_pkg::IWD_CLS_LIT) &&
                   !(w[13:8] == 6'h01 && !w[7]);               // see [RL14]
    d.file_store = d.names_file &&
                   !(d.cls == iwd_pkg::IWD_CLS_BIT && w[11]);
    if (w[13:12] == iwd_pkg::IWD_GRP_BYTE && w[11:8] == iwd_pkg::IWD_OP_DEC_SKIP) begin
      d.skip = iwd_pkg::IWD_SK_ZERO;
    end else if (w[13:12] == iwd_pkg::IWD_GRP_BYTE && w[11:8] == iwd_pkg::IWD_OP_INC_SKIP) begin
      d.skip = iwd_pkg::IWD_SK_ZERO;
    end else if (d.cls == iwd_pkg::IWD_CLS_BIT && w[11:10] == iwd_pkg::IWD_BOP_TEST_CLR) begin
      d.skip = iwd_pkg::IWD_SK_CLR;
    end else if (d.cls == iwd_pkg::IWD_CLS_BIT && w[11:10] == iwd_pkg::IWD_BOP_TEST_SET) begin
      d.skip = iwd_pkg::IWD_SK_SET;
    end
    d.two_cyc = (w[13:12] == iwd_pkg::IWD_GRP_JMP) ||                 // see [RL4] [RL6]
                (w == iwd_pkg::IWD_W_COMP_CALL) ||                    // see [RL4]
                (w == iwd_pkg::IWD_W_SUB_EXIT) ||                     // see [RL5]
                (w == iwd_pkg::IWD_W_INT_EXIT) ||                     // see [RL5]
                (w[13:10] == iwd_pkg::IWD_W_LIT_EXIT) ||              // see [RL5]
                (w == iwd_pkg::IWD_W_ACC_JUMP) ||                     // see [RL6]
                (w[13:9] == iwd_pkg::IWD_W_REL_JUMP);                 // see [RL6]
    d.ptr_upd = (w[13:4] == iwd_pkg::IWD_W_PTR_UPD);
    if (d.ptr_upd) begin
      d.ptr_num  = w[2];                                       // see [RL15]
      d.indirect = 1'b1;
    end else if (w[13:8] == iwd_pkg::IWD_W_PTR_OFS) begin
      d.ptr_num  = w[6];                                       // see [RL15]
      d.indirect = 1'b1;
    end else if (d.names_file && w[6:1] == iwd_pkg::IWD_INDIRECT_HI) begin
      d.ptr_num  = w[0];                                       // see [RL15]
      d.indirect = 1'b1;
    end
    return d;
  endfunction

  iwd_pkg::iwd_s_t   s_q;
  iwd_pkg::iwd_s_t   s_d;
  iwd_pkg::iwd_dec_t dec_new;
  logic [7:0]        mask_new;
  logic              taken;
  logic              ind_hit;

  assign dec_new = decode(instr_in);                           // see [RL1]

  genvar gi;
  generate
    for (gi = 0; gi < iwd_pkg::IWD_DATA_W; gi++) begin : g_mask
      assign mask_new[gi] = (dec_new.bit_idx == 3'(gi));       // see [RL12]
    end
  endgenerate

  always_comb begin
    unique case (s_q.dec.skip)
      iwd_pkg::IWD_SK_CLR:  taken = !test_bit_in;
      iwd_pkg::IWD_SK_SET:  taken = test_bit_in;
      iwd_pkg::IWD_SK_ZERO: taken = result_zero_in;
      default:              taken = 1'b0;
    endcase
    ind_hit = s_q.dec.indirect && ptr_in_prog_in[s_q.dec.ptr_num];
  end

  always_comb begin
    s_d         = s_q;
    s_d.ph      = s_q.ph + 2'h1;                               // see [RL8]
    s_d.fetch   = 1'b0;
    s_d.file_rd = 1'b0;
    s_d.file_wr = 1'b0;
    s_d.acc_wr  = 1'b0;
    s_d.ptr_inc = 1'b0;
    s_d.ptr_dec = 1'b0;
    unique case (s_q.st)
      iwd_pkg::IWD_ST_EXEC: begin
        if (s_q.ph == iwd_pkg::IWD_PH_LAST) begin
          // instruction cycle boundary, s_d.ph wraps to 0
          s_d.skip_taken = taken;
          s_d.need_two   = s_q.dec.two_cyc || taken;           // see [RL6] [RL21]
          s_d.need_ind   = ind_hit;                            // see [RL7]
          s_d.ncnt       = 2'h1;
          if (s_q.dec.two_cyc || taken || ind_hit) begin
            s_d.st    = iwd_pkg::IWD_ST_SECOND;
            s_d.flush = s_q.dec.two_cyc || taken;
            s_d.busy  = 1'b1;
          end else begin
            s_d.fetch = 1'b1;                                  // see [RL3] [RL21]
            s_d.ncyc  = 2'h1;
          end
        end
        if (s_q.fetch) begin
          // word taken at this edge; don't-care bits never compared
          s_d.dec        = dec_new;                            // see [RL14]
          s_d.mask       = mask_new;
          s_d.rd_done    = 1'b0;
          s_d.skip_taken = 1'b0;
          s_d.need_two   = 1'b0;
          s_d.need_ind   = 1'b0;
          s_d.flush      = 1'b0;
          s_d.busy       = 1'b0;
        end
        // word is taken at this very edge, so the fresh decode must decide
        if (s_q.ph == iwd_pkg::IWD_PH_READ && dec_new.names_file) begin
          s_d.file_rd = 1'b1;                                  // see [RL9] [RL10]
          s_d.rd_done = 1'b1;
        end
        if (s_q.ph == iwd_pkg::IWD_PH_READ && dec_new.ptr_upd && !dec_new.ptr_mode[1]) begin
          s_d.ptr_inc = !dec_new.ptr_mode[0];                  // see [RL16]
          s_d.ptr_dec = dec_new.ptr_mode[0];                   // see [RL16]
        end
        if (s_q.ph == iwd_pkg::IWD_PH_WRITE && s_q.dec.file_store) begin
          s_d.file_wr = s_q.dec.dest_file;                     // see [RL9] [RL13]
          s_d.acc_wr  = !s_q.dec.dest_file;                    // see [RL13]
        end
        if (s_q.ph == iwd_pkg::IWD_PH_WRITE && s_q.dec.ptr_upd && s_q.dec.ptr_mode[1]) begin
          s_d.ptr_inc = !s_q.dec.ptr_mode[0];                  // see [RL16]
          s_d.ptr_dec = s_q.dec.ptr_mode[0];                   // see [RL16]
        end
      end
      iwd_pkg::IWD_ST_SECOND: begin
        if (s_q.ph == iwd_pkg::IWD_PH_LAST) begin
          s_d.ncnt = 2'h2;
          if (s_q.need_two && s_q.need_ind) begin
            s_d.st = iwd_pkg::IWD_ST_THIRD;                    // see [RL7]
          end else begin
            s_d.st    = iwd_pkg::IWD_ST_EXEC;
            s_d.fetch = 1'b1;                                  // see [RL4] [RL5] [RL6]
            s_d.ncyc  = 2'h2;
          end
        end
      end
      iwd_pkg::IWD_ST_THIRD: begin
        if (s_q.ph == iwd_pkg::IWD_PH_LAST) begin
          s_d.ncnt  = 2'h3;
          s_d.st    = iwd_pkg::IWD_ST_EXEC;
          s_d.fetch = 1'b1;
          s_d.ncyc  = 2'h3;
        end
      end
      default: begin
        s_d = iwd_pkg::IWD_S_RESET;
      end
    endcase
  end

  // clock enable freezes phase, state and every strobe together
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= iwd_pkg::IWD_S_RESET;
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  assign fetch_out    = s_q.fetch;
  assign phase_out    = s_q.ph;
  assign dec_out      = s_q.dec;
  assign bit_mask_out = s_q.mask;
  assign file_rd_out  = s_q.file_rd;
  assign file_wr_out  = s_q.file_wr;
  assign acc_wr_out   = s_q.acc_wr;
  assign flush_out    = s_q.flush;
  assign ptr_inc_out  = s_q.ptr_inc;
  assign ptr_dec_out  = s_q.ptr_dec;
  assign busy_out     = s_q.busy;
  assign cycles_out   = s_q.ncyc;

  // helper: enabled clocks between two taken words
  logic [3:0] osc_cnt_q;
  logic       seen_q;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      osc_cnt_q <= 4'h0;
      seen_q    <= 1'b0;
    end else if (clk_en_in) begin
      if (s_q.fetch) begin
        osc_cnt_q <= 4'h1;
        seen_q    <= 1'b1;
      end else begin
        osc_cnt_q <= osc_cnt_q + 4'h1;
      end
    end
  end

  property p_phase_wrap;
    @(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && s_q.ph == 2'h3 |=> s_q.ph == 2'h0;
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("phase did not wrap"); // see [RL8]

  property p_cycle_length;
    @(posedge core_clk_in) disable iff (rst_in)
      s_q.fetch && seen_q |-> osc_cnt_q == {s_q.ncyc, 2'h0};
  endproperty
  a_cycle_length: assert property (p_cycle_length) else $error("length wrong"); // see [RL3]

  property p_two_cycle;
    @(posedge core_clk_in) disable iff (rst_in)
      s_q.fetch && seen_q && s_q.dec.two_cyc |-> s_q.ncyc >= 2'h2;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("jump too short"); // see [RL4]

  property p_skip_untaken;
    @(posedge core_clk_in) disable iff (rst_in)
      s_q.fetch && seen_q && s_q.dec.skip != iwd_pkg::IWD_SK_NONE && !s_q.skip_taken &&
      !s_q.need_ind |-> s_q.ncyc == 2'h1;
  endproperty
  a_skip_untaken: assert property (p_skip_untaken) else $error("skip too long"); // see [RL21]

  property p_indirect_extra;
    @(posedge core_clk_in) disable iff (rst_in)
      s_q.fetch && seen_q && s_q.need_ind |-> s_q.ncyc == (s_q.need_two ? 2'h3 : 2'h2);
  endproperty
  a_indirect_extra: assert property (p_indirect_extra) else $error("stall missing"); // see [RL7]

  property p_read_first;
    @(posedge core_clk_in) disable iff (rst_in)
      s_q.file_wr || s_q.acc_wr |-> s_q.rd_done && s_q.ph == 2'h3;
  endproperty
  a_read_first: assert property (p_read_first) else $error("store without prior read"); // see [RL10]

  property p_dest_sel;
    @(posedge core_clk_in) disable iff (rst_in)
      s_q.acc_wr |-> !s_q.dec.dest_file && !s_q.file_wr;
  endproperty
  a_dest_sel: assert property (p_dest_sel) else $error("wrong destination"); // see [RL13]

  property p_mask_onehot;
    @(posedge core_clk_in) disable iff (rst_in)
      seen_q |-> s_q.mask == 8'(8'h01 << s_q.dec.bit_idx);
  endproperty
  a_mask_onehot: assert property (p_mask_onehot) else $error("bit mask mismatch"); // see [RL12]

  property p_read_phase;
    @(posedge core_clk_in) disable iff (rst_in)
      s_q.file_rd |-> s_q.ph == 2'h1 && s_q.dec.names_file;
  endproperty
  a_read_phase: assert property (p_read_phase) else $error("read misplaced"); // see [RL10]

  property p_ptr_phase;
    @(posedge core_clk_in) disable iff (rst_in)
      s_q.ptr_inc || s_q.ptr_dec |-> s_q.dec.ptr_upd && s_q.ph == {s_q.dec.ptr_mode[1], 1'b1};
  endproperty
  a_ptr_phase: assert property (p_ptr_phase) else $error("pointer update misplaced"); // see [RL16]

  property p_flush_cause;
    @(posedge core_clk_in) disable iff (rst_in)
      s_q.flush && s_q.fetch |-> s_q.dec.two_cyc || s_q.skip_taken;
  endproperty
  a_flush_cause: assert property (p_flush_cause) else $error("flush without jump"); // see [RL6]

  property p_third_entry;
    @(posedge core_clk_in) disable iff (rst_in)
      s_q.st == iwd_pkg::IWD_ST_THIRD |-> s_q.need_two && s_q.need_ind && s_q.ncnt == 2'h2;
  endproperty
  a_third_entry: assert property (p_third_entry) else $error("third cycle unjustified"); // see [RL7]

  property p_fetch_slot;
    @(posedge core_clk_in) disable iff (rst_in)
      s_q.fetch |-> s_q.ph == 2'h0 && s_q.st == iwd_pkg::IWD_ST_EXEC;
  endproperty
  a_fetch_slot: assert property (p_fetch_slot) else $error("fetch off boundary"); // see [RL3]

  property p_store_named;
    @(posedge core_clk_in) disable iff (rst_in)
      s_q.file_wr |-> s_q.dec.names_file && s_q.dec.dest_file;
  endproperty
  a_store_named: assert property (p_store_named) else $error("store to unnamed file"); // see [RL9]

  property p_freeze;
    @(posedge core_clk_in) disable iff (rst_in)
      !clk_en_in |=> $stable(s_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

endmodule

// ==== verification/iwd_prog_mem_model.sv ====
// program memory and datapath stand-in facing the instruction decoder
// assumes the bench loads the next word and datapath results per instruction
`timescale 1ns/1ps
module iwd_prog_mem_model (
  input  wire logic        fetch_in,
  input  wire logic [13:0] word_in,
  input  wire logic        bit_in,
  input  wire logic        zero_in,
  input  wire logic [1:0]  prog_in,
  output logic [13:0]      instr_out,
  output logic             test_bit_out,
  output logic             result_zero_out,
  output logic [1:0]       ptr_in_prog_out
);
  // unselected memory shows the inverse, so a late sample cannot match by luck
  assign instr_out       = fetch_in ? word_in : ~word_in;
  assign test_bit_out    = bit_in;
  assign result_zero_out = zero_in;
  assign ptr_in_prog_out = prog_in;
endmodule

// ==== verification/iwd_decode_timing_bench.sv ====
// self-checking bench for the instruction word decoder
// assumes the memory model answers combinationally while fetch_out is high
`timescale 1ns/1ps
module iwd_decode_timing_bench;
  logic              core_clk_in, rst_in, clk_en_in, test_bit_in, result_zero_in;
  logic [13:0]       instr_in, word_r;
  logic [1:0]        ptr_in_prog_in, prog_r, phase_out, cycles_out, ptr_ph;
  logic              fetch_out, file_rd_out, file_wr_out, acc_wr_out, flush_out;
  logic              ptr_inc_out, ptr_dec_out, busy_out, bit_r, zero_r;
  logic [7:0]        bit_mask_out, mask_r;
  iwd_pkg::iwd_dec_t dec_out, dec_r;
  int                num_errors, checked, n_clk, n_rd, n_wr, n_acc, n_fl, n_bz;
  int                n_inc, n_dec;

  iwd_decode_timing dut_u (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .instr_in(instr_in), .test_bit_in(test_bit_in), .result_zero_in(result_zero_in),
    .ptr_in_prog_in(ptr_in_prog_in), .fetch_out(fetch_out), .phase_out(phase_out),
    .dec_out(dec_out), .bit_mask_out(bit_mask_out), .file_rd_out(file_rd_out),
    .file_wr_out(file_wr_out), .acc_wr_out(acc_wr_out), .flush_out(flush_out),
    .ptr_inc_out(ptr_inc_out), .ptr_dec_out(ptr_dec_out), .busy_out(busy_out),
    .cycles_out(cycles_out)
  );

  iwd_prog_mem_model mem_u (
    .fetch_in(fetch_out), .word_in(word_r), .bit_in(bit_r), .zero_in(zero_r),
    .prog_in(prog_r), .instr_out(instr_in), .test_bit_out(test_bit_in),
    .result_zero_out(result_zero_in), .ptr_in_prog_out(ptr_in_prog_in)
  );

  initial core_clk_in = 1'b0;
  always #25 core_clk_in = ~core_clk_in;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one instruction from take to next fetch; strobes counted on enabled edges only
  task automatic exec(input logic [13:0] w, input logic tb, input logic zr,
                      input logic [1:0] pp, input logic stall, input int exp);
    logic en;
    logic done;
    n_clk = 0; n_rd = 0; n_wr = 0; n_acc = 0; n_fl = 0; n_bz = 0; n_inc = 0; n_dec = 0;
    while (fetch_out !== 1'b1) @(negedge core_clk_in);
    word_r = w; bit_r = tb; zero_r = zr; prog_r = pp;
    done = 1'b0;
    while (!done) begin
      en = clk_en_in;
      @(negedge core_clk_in);
      if (en) begin
        n_clk++;
        if (n_clk == 1) begin
          dec_r = dec_out;
          mask_r = bit_mask_out;
        end
        if (ptr_inc_out === 1'b1 || ptr_dec_out === 1'b1) ptr_ph = phase_out;
        n_rd += int'(file_rd_out === 1'b1);
        n_wr += int'(file_wr_out === 1'b1);
        n_acc += int'(acc_wr_out === 1'b1);
        n_fl += int'(flush_out === 1'b1);
        n_bz += int'(busy_out === 1'b1);
        n_inc += int'(ptr_inc_out === 1'b1);
        n_dec += int'(ptr_dec_out === 1'b1);
      end
      done = (en && fetch_out === 1'b1) || n_clk > 16;
      // stalling toggles the enable; counts over enabled edges must not change
      if (!done) clk_en_in = stall ? ~en : 1'b1;
    end
    check(n_clk, 4 * exp, "fetch spacing");
    check(cycles_out, exp, "cycle count");
    // busy still stands in the fetch phase that closes the last extra cycle
    check(n_bz, exp > 1 ? 4 * exp - 3 : 0, "busy span");
  endtask

  task automatic t_byte;
    logic [6:0] k0;
    logic [6:0] k1;
    for (int d = 0; d < 2; d++) begin
      exec({2'h0, 4'h7, d[0], 7'h7F}, 1'b0, 1'b0, 2'h0, 1'b0, 1);
      check(dec_r.cls, iwd_pkg::IWD_CLS_BYTE, "byte class");
      check(dec_r.f_addr, 7'h7F, "file address");
      check(dec_r.dest_file, d, "destination");
      check(n_rd, 1, "file read");
      check(n_wr, d, "file write");
      check(n_acc, 1 - d, "acc write");
    end
    // store-only op must still read first
    exec(14'h0095, 1'b0, 1'b0, 2'h0, 1'b0, 1);
    check(n_rd, 1, "read on store");
    check(n_wr, 1, "store write");
    exec(14'h0100, 1'b0, 1'b0, 2'h0, 1'b0, 1);
    k0 = {dec_r.cls, dec_r.names_file, dec_r.file_store, dec_r.skip, dec_r.indirect};
    check(n_rd, 0, "no file read");
    exec(14'h0103, 1'b0, 1'b0, 2'h0, 1'b0, 1);
    // raw operand fields follow the ignored bits; the decisions must not
    k1 = {dec_r.cls, dec_r.names_file, dec_r.file_store, dec_r.skip, dec_r.indirect};
    check(k1, k0, "ignored bits");
    check(n_rd, 0, "ignored bits read");
  endtask

  task automatic t_bit;
    for (int b = 0; b < 8; b++) begin
      exec({2'h1, 2'h1, b[2:0], 7'h05}, 1'b0, 1'b0, 2'h0, 1'b0, 1);
      check(dec_r.cls, iwd_pkg::IWD_CLS_BIT, "bit class");
      check(dec_r.bit_idx, b, "bit index");
      check(mask_r, 8'h01 << b, "bit mask");
      check(dec_r.f_addr, 7'h05, "bit file address");
      check(n_wr, 1, "bit write");
    end
  endtask

  task automatic t_flow;
    logic [13:0] w [9] = '{14'h25A5, 14'h2AC3, 14'h34A5, 14'h0008, 14'h0009,
                           14'h000A, 14'h000B, 14'h321F, 14'h30A5};
    int          c [9] = '{2, 2, 2, 2, 2, 2, 2, 2, 1};
    for (int i = 0; i < 9; i++) begin
      exec(w[i], 1'b0, 1'b0, 2'h0, 1'b0, c[i]);
      check(dec_r.cls, iwd_pkg::IWD_CLS_LIT, "control class");
      check(n_fl, c[i] > 1 ? 4 * c[i] - 3 : 0, "flush span");
      if (i < 2) check(dec_r.lit11, w[i][10:0], "long target");
      if (i == 2 || i == 8) check(dec_r.lit8, w[i][7:0], "immediate");
    end
  endtask

  task automatic t_skip;
    logic [13:0] w [8] = '{14'h19A0, 14'h19A0, 14'h1DA0, 14'h1DA0,
                           14'h0BA0, 14'h0BA0, 14'h0FA0, 14'h0FA0};
    logic        v [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 8; i++) begin
      // pointers in program memory must not matter for a direct address
      exec(w[i], i < 4 ? v[i] : 1'b0, i < 4 ? 1'b0 : v[i], 2'h3, 1'b0, 2 - i % 2);
      check(n_fl, 5 * (1 - i % 2), "skip flush");
    end
  endtask

  task automatic t_ind;
    logic [6:0] f [5] = '{7'h00, 7'h00, 7'h01, 7'h01, 7'h00};
    logic [1:0] p [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h1};
    logic       s [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    int         c [5] = '{1, 2, 2, 1, 2};
    for (int i = 0; i < 5; i++) begin
      exec({2'h0, 4'h7, 1'b1, f[i]}, 1'b0, 1'b0, p[i], s[i], c[i]);
      check(n_rd, 1, "indirect read");
    end
    // taken count skip through a pointer into program memory: jump plus stall
    exec(14'h0B80, 1'b0, 1'b1, 2'h1, 1'b0, 3);
    check(n_fl, 9, "three-cycle flush");
  endtask

  task automatic t_ptr;
    for (int n = 0; n < 2; n++) begin
      for (int m = 0; m < 4; m++) begin
        exec({10'h001, 1'b0, n[0], m[1:0]}, 1'b0, 1'b0, 2'h0, 1'b0, 1);
        check(dec_r.ptr_num, n, "pointer number");
        check(dec_r.ptr_mode, m, "pointer mode");
        check(n_inc, 1 - m % 2, "pointer increment");
        check(n_dec, m % 2, "pointer decrement");
        check(ptr_ph, m > 1 ? 3 : 1, "update phase");
      end
    end
  endtask

  initial begin
    rst_in = 1'b1; clk_en_in = 1'b1; word_r = 14'h0000; bit_r = 1'b0; zero_r = 1'b0;
    prog_r = 2'h0; ptr_ph = 2'h0; num_errors = 0; checked = 0;
    repeat (10) @(negedge core_clk_in);
    check(phase_out, 3, "reset phase");
    check(fetch_out, 0, "reset fetch");
    rst_in = 1'b0;
    t_byte;
    t_bit;
    t_flow;
    t_skip;
    t_ind;
    t_ptr;
    finish_test;
  end

  // whole run needs well under 2000 clocks
  initial begin
    #(20000 * 50);
    num_errors++;
    finish_test;
  end
endmodule
